// ===== logic/ars_regset.sv
// Architected register set of the core: integer and float arrays,
// condition word, float status word, machine state and segment file.
// Assumes the decode and execute units drive one-cycle requests on mclk.
//
// How it works
// - Operand B from register or immediate; separate target.
// - Memory data moves only on load/store requests.
// - Two privilege levels, supervisor and user, tracked.
// - User access to protected register blocked, exception.
// - Supervisor accesses everything without privilege exception.
// - Condition word is eight 4-bit fields.
// - Thirty-two 64-bit float registers.
// - Float status holds signals, summary, enables, rounding.
// - Thirty-two integer registers, also address float loads.
// - Exception saves machine state; return restores it.
// - Machine state has a sleep-allow bit.
// - Machine state has a performance-mark bit.
// - Sixteen 32-bit segment registers, 256-MB segments.
// - Main copy for data, shadow copy for fetch.
// - Segment write loads both copies.
// - Segment read returns the main copy.
// - Privilege level comes from the machine state bit.
//
// Chosen here: the register addresses and strobed register access.

`timescale 1ns/1ps

module ars_regset (
  // Clock and reset
  input  wire logic                           mclk,
  input  wire logic                           arst_n,
  // Software register port
  input  wire logic [ars_pkg::REG_AW-1:0]     reg_addr,
  input  wire logic [31:0]                    reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [31:0]                    reg_rdata,
  output logic                                irq,
  // Integer operands
  input  wire logic                           op_valid,
  input  wire logic [ars_pkg::IDX_W-1:0]      op_ra_idx,
  input  wire logic [ars_pkg::IDX_W-1:0]      op_rb_idx,
  input  wire logic                           op_use_imm,
  input  wire logic [ars_pkg::IMM_W-1:0]      op_imm,
  output logic      [ars_pkg::GPR_W-1:0]      opnd_a,
  output logic      [ars_pkg::GPR_W-1:0]      opnd_b,
  // Integer result write-back
  input  wire logic                           gwr_en,
  input  wire logic [ars_pkg::IDX_W-1:0]      gwr_idx,
  input  wire logic [ars_pkg::GPR_W-1:0]      gwr_data,
  // Float operands and write-back
  input  wire logic                           fop_valid,
  input  wire logic [ars_pkg::IDX_W-1:0]      fa_idx,
  input  wire logic [ars_pkg::IDX_W-1:0]      fb_idx,
  output logic      [ars_pkg::FPR_W-1:0]      fopnd_a,
  output logic      [ars_pkg::FPR_W-1:0]      fopnd_b,
  input  wire logic                           fwr_en,
  input  wire logic [ars_pkg::IDX_W-1:0]      fwr_idx,
  input  wire logic [ars_pkg::FPR_W-1:0]      fwr_data,
  // Load and store
  input  wire logic                           ls_valid,
  input  wire logic                           ls_store,
  input  wire logic                           ls_float,
  input  wire logic [ars_pkg::IDX_W-1:0]      ls_base_idx,
  input  wire logic [ars_pkg::IDX_W-1:0]      ls_src_idx,
  input  wire logic [ars_pkg::OFFS_W-1:0]     ls_offset,
  output logic                                ls_req,
  output logic                                ls_wr,
  output logic      [ars_pkg::EA_W-1:0]       ls_ea,
  output logic      [ars_pkg::FPR_W-1:0]      ls_sdata,
  input  wire logic                           ld_valid,
  input  wire logic                           ld_float,
  input  wire logic [ars_pkg::IDX_W-1:0]      ld_idx,
  input  wire logic [ars_pkg::FPR_W-1:0]      ld_data,
  // Condition word
  input  wire logic                           cr_wr_en,
  input  wire logic [ars_pkg::CR_SEL_W-1:0]   cr_field,
  input  wire logic [ars_pkg::CR_FW-1:0]      cr_value,
  output logic      [31:0]                    condition_flags_reg,
  // Float exceptions and controls
  input  wire logic [ars_pkg::FPS_EXC_W-1:0]  fp_exc_set,
  output logic      [ars_pkg::FPS_RN_W-1:0]   fp_round_mode,
  output logic                                fp_trap,
  // Protected register access
  input  wire logic                           sa_valid,
  input  wire logic                           sa_write,
  input  wire logic                           sa_seg,
  input  wire logic [ars_pkg::SEG_IDX_W-1:0]  sa_idx,
  input  wire logic [31:0]                    sa_wdata,
  output logic      [31:0]                    sa_rdata,
  output logic                                prog_exc,
  // Exception entry and return
  input  wire logic                           exc_take,
  input  wire logic                           exc_return,
  // Machine state views
  output logic                                user_mode,
  output logic                                sleep_allow_bit,
  output logic                                perf_mark_bit,
  // Segment lookups
  input  wire logic [ars_pkg::EA_W-1:0]       d_ea,
  input  wire logic [ars_pkg::EA_W-1:0]       i_ea,
  output logic      [ars_pkg::SEG_W-1:0]      d_seg,
  output logic      [ars_pkg::SEG_W-1:0]      i_seg
);
  import ars_pkg::*;

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [31:0]       machine_state_reg;
    logic [31:0]       saved_msr;
    logic [31:0]       cr;
    logic [31:0]       float_status_control;
    logic [ST_W-1:0]   status;
    logic [ST_W-1:0]   mask;
    logic              irq;
    logic [31:0]       rdata;
    logic [GPR_W-1:0]  opnd_a;
    logic [GPR_W-1:0]  opnd_b;
    logic [FPR_W-1:0]  fopnd_a;
    logic [FPR_W-1:0]  fopnd_b;
    logic              ls_req;
    logic              ls_wr;
    logic [EA_W-1:0]   ls_ea;
    logic [FPR_W-1:0]  ls_sdata;
    logic [31:0]       sa_rdata;
    logic              prog_exc;
    logic [SEG_W-1:0]  d_seg;
    logic [SEG_W-1:0]  i_seg;
  } ars_state_s;

  ars_state_s q;
  ars_state_s d;

  logic [GPR_RD-1:0][IDX_W-1:0] g_ridx;
  logic [GPR_RD-1:0][GPR_W-1:0] g_rdat;
  logic [FPR_RD-1:0][IDX_W-1:0] f_ridx;
  logic [FPR_RD-1:0][FPR_W-1:0] f_rdat;
  logic                         g_we;
  logic [IDX_W-1:0]             g_widx;
  logic [GPR_W-1:0]             g_wdat;
  logic                         f_we;
  logic [IDX_W-1:0]             f_widx;
  logic [FPR_W-1:0]             f_wdat;
  logic                         seg_we;
  logic [SEG_W-1:0]             seg_rd;
  logic [SEG_W-1:0]             seg_dd;
  logic [SEG_W-1:0]             seg_id;
  ars_priv_e                    priv;
  logic                         sa_ok;
  logic                         sa_block;
  logic [ST_W-1:0]              st_set;
  logic [ST_W-1:0]              st_clr;
  logic [FPS_EXC_W-1:0]         fp_exc;
  logic [FPS_EXC_W-1:0]         fp_ena;

  // ---------------------------------------------------------------------
  // Register arrays
  // ---------------------------------------------------------------------

  // Integer ports: A, B, load/store base, store source.
  assign g_ridx = {ls_src_idx, ls_base_idx, op_rb_idx, op_ra_idx};
  // Float ports: A, B, store source.
  assign f_ridx = {ls_src_idx, fb_idx, fa_idx};

  // Loaded data wins the write port over a result in the same cycle.
  assign g_we   = (ld_valid & ~ld_float) | gwr_en;
  assign g_widx = (ld_valid & ~ld_float) ? ld_idx : gwr_idx;
  assign g_wdat = (ld_valid & ~ld_float) ? ld_data[GPR_W-1:0] : gwr_data;
  assign f_we   = (ld_valid & ld_float) | fwr_en;
  assign f_widx = (ld_valid & ld_float) ? ld_idx : fwr_idx;
  assign f_wdat = (ld_valid & ld_float) ? ld_data : fwr_data;

  // Thirty-two integer registers with separate target index.
  ars_reg_array #(
    .W   (GPR_W),
    .NRD (GPR_RD)
  ) u_gpr (
    .mclk   (mclk),
    .arst_n (arst_n),
    .we     (g_we),
    .widx   (g_widx),
    .wdat   (g_wdat),
    .ridx   (g_ridx),
    .rdat   (g_rdat)
  );

  // Thirty-two double-width float registers.
  ars_reg_array #(
    .W   (FPR_W),
    .NRD (FPR_RD)
  ) u_fpr (
    .mclk   (mclk),
    .arst_n (arst_n),
    .we     (f_we),
    .widx   (f_widx),
    .wdat   (f_wdat),
    .ridx   (f_ridx),
    .rdat   (f_rdat)
  );

  // ---------------------------------------------------------------------
  // Segment file
  // ---------------------------------------------------------------------

  // Only a permitted protected write reaches the descriptors.
  assign seg_we = sa_ok & sa_write & sa_seg;

  // Sixteen descriptors, selected by the top address nibble.
  ars_seg_file u_seg (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .wr_en   (seg_we),
    .sel_idx (sa_idx),
    .wr_data (sa_wdata),
    .rd_data (seg_rd),
    .d_idx   (d_ea[EA_W-1:SEG_SEL_LSB]),
    .i_idx   (i_ea[EA_W-1:SEG_SEL_LSB]),
    .d_data  (seg_dd),
    .i_data  (seg_id)
  );

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------

  // Computes every register's next value from the current cycle's inputs.
  always_comb begin
    d = q;
    st_set = '0;
    st_clr = '0;

    // Privilege level follows the machine state bit.
    priv = q.machine_state_reg[MSR_PR_BIT] ? PRIV_USR : PRIV_SUP;
    sa_ok    = sa_valid & (priv == PRIV_SUP);
    sa_block = sa_valid & (priv == PRIV_USR);

    // Integer operands; B may come from the immediate.
    if (op_valid) begin
      d.opnd_a = g_rdat[0];
      d.opnd_b = op_use_imm ? op_imm : g_rdat[1];
    end

    // Float operands.
    if (fop_valid) begin
      d.fopnd_a = f_rdat[0];
      d.fopnd_b = f_rdat[1];
    end

    // Memory traffic only on a load/store request, address from integers.
    d.ls_req   = ls_valid;
    d.ls_wr    = ls_valid & ls_store;
    d.ls_sdata = '0;
    if (ls_valid) begin
      d.ls_ea = g_rdat[2] + {{(EA_W-OFFS_W){ls_offset[OFFS_W-1]}},
                             ls_offset};
    end
    if (ls_valid && ls_store) begin
      d.ls_sdata = ls_float ? f_rdat[2]
                            : {{(FPR_W-GPR_W){1'b0}}, g_rdat[3]};
    end

    // Condition word: field 0 is the most significant nibble.
    for (int i = 0; i < CR_FIELDS; i++) begin
      if (cr_wr_en && (cr_field == i[CR_SEL_W-1:0])) begin
        d.cr[CR_FW*(CR_FIELDS-1-i) +: CR_FW] = cr_value;
      end
    end

    // Float status: software write, then sticky exception signals.
    if (reg_wr && (reg_addr == OFS_FLOAT_STATUS_CONTROL)) begin
      d.float_status_control = reg_wdata;
    end
    d.float_status_control[FPS_EXC_LSB +: FPS_EXC_W] =
      d.float_status_control[FPS_EXC_LSB +: FPS_EXC_W] | fp_exc_set;
    if (|fp_exc_set) begin
      d.float_status_control[FPS_FX_BIT] = 1'b1;
    end
    fp_exc = d.float_status_control[FPS_EXC_LSB +: FPS_EXC_W];
    fp_ena = d.float_status_control[FPS_ENA_LSB +: FPS_EXC_W];
    d.float_status_control[FPS_FEX_BIT] = |(fp_exc & fp_ena);
    if (|(fp_exc_set & fp_ena)) begin
      st_set[ST_FPT] = 1'b1;
    end

    // Protected access: a user attempt does nothing and raises the fault.
    d.prog_exc = sa_block;
    if (sa_block) begin
      st_set[ST_PROG] = 1'b1;
    end
    if (sa_ok && !sa_write) begin
      d.sa_rdata = sa_seg ? seg_rd : q.machine_state_reg;
    end
    if (sa_ok && sa_write && !sa_seg) begin
      d.machine_state_reg = sa_wdata;
    end

    // Exception entry saves state and drops to supervisor; return restores.
    if (exc_take) begin
      d.saved_msr         = q.machine_state_reg;
      d.machine_state_reg = q.machine_state_reg & ~MSR_EXC_CLR;
      st_set[ST_TAKE]     = 1'b1;
    end else if (exc_return) begin
      d.machine_state_reg = q.saved_msr;
      st_set[ST_RET]      = 1'b1;
    end

    // Status is write-one-to-clear; a new event beats the clear.
    if (reg_wr && (reg_addr == OFS_STATUS)) begin
      st_clr = reg_wdata[ST_W-1:0];
    end
    d.status = (q.status & ~st_clr) | st_set;
    if (reg_wr && (reg_addr == OFS_MASK)) begin
      d.mask = reg_wdata[ST_W-1:0];
    end
    d.irq = |(d.status & d.mask);

    // Register read data stand one cycle after the strobe only.
    d.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_STATUS: d.rdata = {{(32-ST_W){1'b0}}, q.status};
        OFS_MASK:   d.rdata = {{(32-ST_W){1'b0}}, q.mask};
        OFS_MSR:    d.rdata = q.machine_state_reg;
        OFS_CR:     d.rdata = q.cr;
        OFS_FLOAT_STATUS_CONTROL:  d.rdata = q.float_status_control;
        OFS_SAVED:  d.rdata = q.saved_msr;
        default:    d.rdata = '0;
      endcase
    end

    // Segment lookups for data and fetch.
    d.d_seg = seg_dd;
    d.i_seg = seg_id;
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------

  // Holds all state; reset puts the core in supervisor level.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q                      <= '0;
      q.machine_state_reg    <= MSR_RST;
      q.float_status_control <= FLOAT_STATUS_CONTROL_RST;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------

  // All outputs come straight from the state register.
  assign reg_rdata           = q.rdata;
  assign irq                 = q.irq;
  assign opnd_a              = q.opnd_a;
  assign opnd_b              = q.opnd_b;
  assign fopnd_a             = q.fopnd_a;
  assign fopnd_b             = q.fopnd_b;
  assign ls_req              = q.ls_req;
  assign ls_wr               = q.ls_wr;
  assign ls_ea               = q.ls_ea;
  assign ls_sdata            = q.ls_sdata;
  assign condition_flags_reg = q.cr;
  assign fp_round_mode       = q.float_status_control[FPS_RN_LSB +: FPS_RN_W];
  assign fp_trap             = q.float_status_control[FPS_FEX_BIT];
  assign sa_rdata            = q.sa_rdata;
  assign prog_exc            = q.prog_exc;
  assign user_mode           = q.machine_state_reg[MSR_PR_BIT];
  assign sleep_allow_bit     = q.machine_state_reg[MSR_POW_BIT];
  assign perf_mark_bit       = q.machine_state_reg[MSR_PM_BIT];
  assign d_seg               = q.d_seg;
  assign i_seg               = q.i_seg;

endmodule : ars_regset

// ===== logic/ars_pkg.sv
// Shared constants and types of the architected register set.
// Assumes a single core clock and an asynchronous active-low hard reset.

package ars_pkg;

  // ---------------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------------
  localparam int unsigned NREG       = 32;
  localparam int unsigned IDX_W      = 5;
  localparam int unsigned GPR_W      = 32;
  localparam int unsigned FPR_W      = 64;
  localparam int unsigned GPR_RD     = 4;
  localparam int unsigned FPR_RD     = 3;
  localparam int unsigned CR_FIELDS  = 8;
  localparam int unsigned CR_FW      = 4;
  localparam int unsigned CR_SEL_W   = 3;
  localparam int unsigned NSEG       = 16;
  localparam int unsigned SEG_W      = 32;
  localparam int unsigned SEG_IDX_W  = 4;
  localparam int unsigned EA_W       = 32;
  localparam int unsigned SEG_SEL_LSB = EA_W - SEG_IDX_W;
  localparam int unsigned OFFS_W     = 16;
  localparam int unsigned IMM_W      = 32;

  // ---------------------------------------------------------------------
  // Machine state word
  // ---------------------------------------------------------------------
  localparam int unsigned MSR_PR_BIT  = 14;
  localparam int unsigned MSR_POW_BIT = 18;
  localparam int unsigned MSR_PM_BIT  = 2;
  localparam logic [31:0] MSR_RST     = 32'h0000_0000;
  localparam logic [31:0] MSR_EXC_CLR = 32'h0004_4000;

  // ---------------------------------------------------------------------
  // Floating-point status and control word
  // ---------------------------------------------------------------------
  localparam int unsigned FPS_RN_LSB  = 0;
  localparam int unsigned FPS_RN_W    = 2;
  localparam int unsigned FPS_ENA_LSB = 3;
  localparam int unsigned FPS_EXC_LSB = 25;
  localparam int unsigned FPS_EXC_W   = 5;
  localparam int unsigned FPS_FEX_BIT = 30;
  localparam int unsigned FPS_FX_BIT  = 31;
  localparam logic [31:0] FLOAT_STATUS_CONTROL_RST   = 32'h0000_0000;

  // ---------------------------------------------------------------------
  // Software register port
  // ---------------------------------------------------------------------
  localparam int unsigned REG_AW     = 8;
  localparam logic [7:0]  OFS_STATUS = 8'h00;
  localparam logic [7:0]  OFS_MASK   = 8'h04;
  localparam logic [7:0]  OFS_MSR    = 8'h08;
  localparam logic [7:0]  OFS_CR     = 8'h0c;
  localparam logic [7:0]  OFS_FLOAT_STATUS_CONTROL  = 8'h10;
  localparam logic [7:0]  OFS_SAVED  = 8'h14;

  // Event bits of the status and mask registers.
  localparam int unsigned ST_W    = 4;
  localparam int unsigned ST_PROG = 0;
  localparam int unsigned ST_TAKE = 1;
  localparam int unsigned ST_RET  = 2;
  localparam int unsigned ST_FPT  = 3;

  // Current privilege level.
  typedef enum logic [1:0] {
    PRIV_SUP = 2'b01,
    PRIV_USR = 2'b10
  } ars_priv_e;

endpackage : ars_pkg

// ===== logic/ars_reg_array.sv
// Multi-port register array with one write port and NRD read ports.
// Assumes writes and reads share mclk; reads are combinational.

`timescale 1ns/1ps

module ars_reg_array #(
  parameter int unsigned W   = ars_pkg::GPR_W,
  parameter int unsigned NRD = ars_pkg::GPR_RD
) (
  // Clock and reset
  input  wire logic                              mclk,
  input  wire logic                              arst_n,
  // Write port
  input  wire logic                              we,
  input  wire logic [ars_pkg::IDX_W-1:0]         widx,
  input  wire logic [W-1:0]                      wdat,
  // Read ports
  input  wire logic [NRD-1:0][ars_pkg::IDX_W-1:0] ridx,
  output logic      [NRD-1:0][W-1:0]             rdat
);
  import ars_pkg::*;

  logic [W-1:0] mem_q [NREG];

  // Entries clear on reset and take one write per cycle.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NREG; i++) begin
        mem_q[i] <= '0;
      end
    end else if (we) begin
      mem_q[widx] <= wdat;
    end
  end

  // Each read port looks up its entry; a same-cycle write is not seen.
  for (genvar p = 0; p < NRD; p++) begin : g_rd
    assign rdat[p] = mem_q[ridx[p]];
  end

endmodule : ars_reg_array

// ===== logic/ars_seg_file.sv
// Segment descriptors held twice: main copy for data, shadow for fetch.
// Assumes the owner gates writes by privilege before they arrive here.

`timescale 1ns/1ps

module ars_seg_file (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          arst_n,
  // Descriptor write and read
  input  wire logic                          wr_en,
  input  wire logic [ars_pkg::SEG_IDX_W-1:0] sel_idx,
  input  wire logic [ars_pkg::SEG_W-1:0]     wr_data,
  output logic      [ars_pkg::SEG_W-1:0]     rd_data,
  // Lookups
  input  wire logic [ars_pkg::SEG_IDX_W-1:0] d_idx,
  input  wire logic [ars_pkg::SEG_IDX_W-1:0] i_idx,
  output logic      [ars_pkg::SEG_W-1:0]     d_data,
  output logic      [ars_pkg::SEG_W-1:0]     i_data
);
  import ars_pkg::*;

  logic [SEG_W-1:0] main_q   [NSEG];
  logic [SEG_W-1:0] shadow_q [NSEG];

  // One write loads the same entry in both copies.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NSEG; i++) begin
        main_q[i]   <= '0;
        shadow_q[i] <= '0;
      end
    end else if (wr_en) begin
      main_q[sel_idx]   <= wr_data;
      shadow_q[sel_idx] <= wr_data;
    end
  end

  // Reads and data lookups use the main copy, fetch uses the shadow.
  assign rd_data = main_q[sel_idx];
  assign d_data  = main_q[d_idx];
  assign i_data  = shadow_q[i_idx];

endmodule : ars_seg_file

// ===== test/ars_regset_assertions.sv
// Port-level checker of the register set.
// Bound to ars_regset; sees only its ports.

`timescale 1ns/1ps

module ars_regset_chk (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        arst_n,
  // Software port and float controls
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [1:0]  fp_round_mode,
  // Load and store
  input wire logic        ls_valid,
  input wire logic        ls_store,
  input wire logic        ls_req,
  input wire logic        ls_wr,
  // Condition word
  input wire logic        cr_wr_en,
  input wire logic [2:0]  cr_field,
  input wire logic [3:0]  cr_value,
  input wire logic [31:0] condition_flags_reg,
  // Protected access and machine state
  input wire logic        sa_valid,
  input wire logic        sa_write,
  input wire logic        sa_seg,
  input wire logic [31:0] sa_rdata,
  input wire logic        prog_exc,
  input wire logic        exc_take,
  input wire logic        exc_return,
  input wire logic        user_mode,
  input wire logic        sleep_allow_bit
);
  import ars_pkg::*;
  // ------------------------------------
  // Request to result relations
  // ------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_priv;
    sa_valid && user_mode |=> prog_exc && $stable(sa_rdata);
  endproperty
  a_priv: assert property (p_priv) else $error("user access passed");
  property p_sup;
    sa_valid && !user_mode |=> !prog_exc;
  endproperty
  a_sup: assert property (p_sup) else $error("supervisor faulted");
  property p_req;
    ls_valid |=> ls_req;
  endproperty
  a_req: assert property (p_req) else $error("no memory request");
  property p_noreq;
    !ls_valid |=> !ls_req && !ls_wr;
  endproperty
  a_noreq: assert property (p_noreq) else $error("stray request");
  property p_wr;
    ls_valid && ls_store |=> ls_wr;
  endproperty
  a_wr: assert property (p_wr) else $error("store not marked");
  property p_exc;
    exc_take |=> !user_mode && !sleep_allow_bit;
  endproperty
  a_exc: assert property (p_exc) else $error("entry kept state");
  property p_cr;
    cr_wr_en |=>
      condition_flags_reg[31-4*$past(cr_field) -: 4] == $past(cr_value);
  endproperty
  a_cr: assert property (p_cr) else $error("field not written");
  property p_rnd;
    !$stable(fp_round_mode) |-> $past(reg_wr && reg_addr == OFS_FLOAT_STATUS_CONTROL);
  endproperty
  a_rnd: assert property (p_rnd) else $error("rounding moved");
  property p_usr;
    $rose(user_mode) |-> $past(exc_return || sa_valid && sa_write && !sa_seg);
  endproperty
  a_usr: assert property (p_usr) else $error("level moved");
endmodule : ars_regset_chk

bind ars_regset ars_regset_chk u_ars_regset_chk (.*);

// ===== test/ars_core_model.sv
// Decode-unit model that takes the exception after a fault.
// Assumes prog_exc is a one-cycle pulse on mclk.

`timescale 1ns/1ps

module ars_core_model #(
  parameter int unsigned DLY = 3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Fault and exception entry
  input wire logic prog_exc,
  output logic     exc_take
);
  int unsigned cnt;
  // A fault leads to one entry pulse DLY cycles on.
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      exc_take <= 1'b0;
    end else begin
      exc_take <= (cnt == 1);
      cnt <= prog_exc ? DLY : (cnt != 0 ? cnt - 1 : 0);
    end
  end
endmodule : ars_core_model

// ===== test/tb_top.sv
// Directed bench of the register set beside a decode-unit model.
// Assumes the package and design files are compiled first.

`timescale 1ns/1ps

module tb_top;
  import ars_pkg::*;
  logic mclk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, op_valid = 0;
  logic op_use_imm = 0, gwr_en = 0, fop_valid = 0, fwr_en = 0;
  logic ls_valid = 0, ls_store = 0, ls_float = 0, ld_valid = 0;
  logic ld_float = 0, cr_wr_en = 0, sa_valid = 0, sa_write = 0;
  logic sa_seg = 0, exc_return = 0, irq, ls_req, ls_wr, fp_trap;
  logic prog_exc, exc_take, user_mode, sleep_allow_bit, perf_mark_bit;
  logic [4:0] op_ra_idx = 0, op_rb_idx = 0, gwr_idx = 0, fa_idx = 0;
  logic [4:0] fb_idx = 0, fwr_idx = 0, ls_base_idx = 0, ls_src_idx = 0;
  logic [4:0] ld_idx = 0, fp_exc_set = 0;
  logic [31:0] reg_wdata = 0, op_imm = 0, gwr_data = 0, sa_wdata = 0;
  logic [31:0] d_ea = 0, i_ea = 0, reg_rdata, opnd_a, opnd_b, ls_ea;
  logic [31:0] condition_flags_reg, sa_rdata, d_seg, i_seg;
  logic [63:0] fwr_data = 0, ld_data = 0, fopnd_a, fopnd_b, ls_sdata;
  logic [7:0]  reg_addr = 0;
  logic [15:0] ls_offset = 0;
  logic [3:0]  cr_value = 0, sa_idx = 0;
  logic [2:0]  cr_field = 0;
  logic [1:0]  fp_round_mode;
  int failures = 0, samples_checked = 0;

  ars_regset u_ars_regset (.*);
  ars_core_model #(.DLY(3)) u_ars_core_model (.*);

  // Core clock of 100 ns.
  always #50 mclk = ~mclk;

  task automatic chk(input logic [63:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge mclk);
    reg_wr <= 0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge mclk);
    reg_rd <= 0;
    #1 chk(reg_rdata, e);
  endtask : rdc
  task automatic sa(input logic w, s, input logic [3:0] i,
                    input logic [31:0] d);
    @(posedge mclk);
    {sa_valid, sa_write, sa_seg, sa_idx, sa_wdata} <= {1'b1, w, s, i, d};
    @(posedge mclk);
    sa_valid <= 0;
    #1;
  endtask : sa
  task automatic report_and_stop;
    $display("checked %0d, failed %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Ends a hung run.
  initial begin
    #(2000 * 100);
    failures++;
    report_and_stop();
  end

  // Test sequence.
  initial begin
    repeat (4) @(posedge mclk);
    arst_n <= 1;
    wr(OFS_MSR, 32'hffff_ffff);
    rdc(OFS_MSR, 32'h0);
    rdc(8'h40, 32'h0);
    $display("test reset done");
    @(posedge mclk);
    {gwr_en, gwr_idx, gwr_data} <= {1'b1, 5'd5, 32'h1234_5678};
    {fwr_en, fwr_idx, fwr_data} <= {1'b1, 5'd31, 64'h0123_4567_89ab_cdef};
    @(posedge mclk);
    {gwr_en, fwr_en, ld_valid, ld_idx, ld_data} <= {3'b001, 5'd7, 64'hab};
    @(posedge mclk);
    {ld_valid, op_valid, op_ra_idx} <= {2'b01, 5'd7};
    {op_use_imm, op_imm, fop_valid, fa_idx} <= {1'b1, 32'h5, 1'b1, 5'd31};
    {ls_valid, ls_store, ls_float} <= 3'b111;
    {ls_base_idx, ls_src_idx, ls_offset} <= {5'd5, 5'd31, 16'hfffc};
    @(posedge mclk);
    {op_valid, fop_valid, ls_valid} <= 3'b000;
    #1 chk(opnd_a, 32'hab);
    chk(opnd_b, 32'h5);
    chk(fopnd_a, 64'h0123_4567_89ab_cdef);
    chk(fopnd_b, 64'h0);
    chk(ls_ea, 32'h1234_5674);
    chk(ls_sdata, 64'h0123_4567_89ab_cdef);
    chk({ls_req, ls_wr}, 2'b11);
    $display("test operands done");
    @(posedge mclk);
    {cr_wr_en, cr_field, cr_value} <= {1'b1, 3'd0, 4'ha};
    @(posedge mclk);
    cr_wr_en <= 0;
    #1 chk(condition_flags_reg, 32'ha000_0000);
    wr(OFS_FLOAT_STATUS_CONTROL, 32'h0000_000a);
    tick(1);
    chk(fp_round_mode, 2'd2);
    @(posedge mclk);
    fp_exc_set <= 5'h01;
    @(posedge mclk);
    fp_exc_set <= 0;
    tick(1);
    chk(fp_trap, 1);
    rdc(OFS_FLOAT_STATUS_CONTROL, 32'hc200_000a);
    $display("test status done");
    sa(1, 1, 4'd2, 32'hcafe_0002);
    sa(0, 1, 4'd2, 0);
    chk(sa_rdata, 32'hcafe_0002);
    @(posedge mclk);
    {d_ea, i_ea} <= {32'h2000_0000, 32'h2fff_fff0};
    tick(2);
    chk({d_seg, i_seg}, {2{32'hcafe_0002}});
    $display("test segments done");
    sa(1, 0, 4'd0, 32'h0004_4004);
    chk({user_mode, sleep_allow_bit, perf_mark_bit}, 3'b111);
    sa(0, 1, 4'd0, 0);
    chk({prog_exc, sa_rdata}, {1'b1, 32'hcafe_0002});
    for (int i = 0; i < 20 && user_mode !== 1'b0; i++) tick(1);
    chk(user_mode, 0);
    rdc(OFS_SAVED, 32'h0004_4004);
    rdc(OFS_STATUS, 32'hb);
    chk(irq, 0);
    wr(OFS_MASK, 32'h1);
    tick(1);
    chk(irq, 1);
    wr(OFS_STATUS, 32'hf);
    tick(1);
    chk(irq, 0);
    @(posedge mclk);
    exc_return <= 1;
    @(posedge mclk);
    exc_return <= 0;
    #1 chk(user_mode, 1);
    rdc(OFS_MSR, 32'h0004_4004);
    $display("test privilege done");
    report_and_stop();
  end
endmodule : tb_top
